// file: verilog/fcpwm_pkg.sv
/*
  Constants, register map and state type of the four-channel pwm with brake.
  Assumes a single 20 MHz clock and an apb master on the register side.
*/
// Summary of operation
// - compare is 10 bits: low byte per channel, top bits from a shared register
// - underflow drives output high; it goes low at compare until next underflow
// - high time equals reload minus compare plus one clocks
// - compare above reload, except all ones, keeps the output permanently high
// - compare of all zeros keeps the output permanently high
// - compare of all ones keeps the output permanently low
// - compare writes land in shadows and move only by transfer
// - per-channel invert bits 5, 4, 2, 1 swap the output levels
// - transfer bit 6 copies shadows at next underflow, then clears itself
// - run bit 7 starts the down counter; clear halts it
// - transfers happen only at underflow, never while halted
// - rewriting control with run but no transfer cancels a pending transfer
// - when run clears, outputs hold their last levels while halted
// - during brake outputs take the four brake-level bits
// - brake acts only with enable bit 4; with no mode bits it is always on
// - brake-on-stop bit 7 brakes whenever run is zero
// - pin mode brakes when brake input matches the polarity bit
// - a pin-caused brake clears the run bit
// - after brake, outputs return to the levels held before it
// - period counter is a 10-bit down counter reloaded at underflow
// - after reset each internal channel output is one
// - reload writes land in a shadow and move only by transfer
package fcpwm_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MAIN_CTL  = 8'h00;
  localparam logic [7:0] OFS_BRAKE_CTL = 8'h04;
  localparam logic [7:0] OFS_CMP_SH0   = 8'h08;
  localparam logic [7:0] OFS_CMP_SH4   = 8'h18;
  localparam logic [7:0] OFS_RLD_SH0   = 8'h1c;
  localparam logic [7:0] OFS_RLD_SH1   = 8'h20;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int RUN_BIT     = 7;
  localparam int SHADOW_TRANSFER_REQUEST_BIT    = 6;
  localparam int INV3_BIT    = 5;
  localparam int INV2_BIT    = 4;
  localparam int INV1_BIT    = 2;
  localparam int INV0_BIT    = 1;
  localparam int BK_STOP_BIT = 7;
  localparam int BK_POL_BIT  = 6;
  localparam int BK_PIN_BIT  = 5;
  localparam int BK_EN_BIT   = 4;

  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [7:0] MAIN_CTL_RST  = 8'h00;
  localparam logic [7:0] BRAKE_CTL_RST = 8'h00;
  localparam logic [7:0] SHADOW_RST    = 8'h00;
  localparam logic [9:0] CNT_RST       = 10'h000;
  localparam logic [9:0] CMP_ZERO      = 10'h000;
  localparam logic [9:0] CMP_ONES      = 10'h3ff;
  localparam logic [3:0] WAVE_RST      = 4'hf;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [9:0]       cnt;
    logic [9:0]       reload;
    logic [3:0][9:0]  cmp;
    logic [7:0]       main_ctl;
    logic [7:0]       brake_ctl;
    logic [3:0][7:0]  cmp_lo;
    logic [7:0]       cmp_hi;
    logic [7:0]       rld_lo;
    logic [1:0]       rld_hi;
    logic [3:0]       wave;
    logic [3:0]       out;
    logic [2:0]       sync;
    logic             pin;
    logic             rdy;
    logic             err;
    logic [31:0]      rdata;
  } fcpwm_state_t;

endpackage

// file: verilog/fcpwm_top.sv
/*
  Four-channel pwm with shared 10-bit period counter, shadowed compare and
  reload values, per-channel invert and a brake function.
  Assumes an apb master on clk and an asynchronous brake input pin.
*/
`timescale 1ns/100ps
module fcpwm_top
  import fcpwm_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // brake pin
  input  wire logic        brake_input,
  // waveform outputs
  output      logic        wave_out_0,
  output      logic        wave_out_1,
  output      logic        wave_out_2,
  output      logic        wave_out_3
);

  fcpwm_state_t s_q;
  fcpwm_state_t s_d;

  logic [3:0] inv;
  logic       run;
  logic       shadow_transfer_request;
  logic       underflow;
  logic       pin_match;
  logic       pin_brake;
  logic       brake;
  logic       setup;
  logic       access;
  logic       wr_main;
  logic [9:0] cmp_sh;
  logic [31:0] rd_val;
  logic       rd_err;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  assign run     = s_q.main_ctl[RUN_BIT];
  assign shadow_transfer_request    = s_q.main_ctl[SHADOW_TRANSFER_REQUEST_BIT];
  assign inv     = {s_q.main_ctl[INV3_BIT], s_q.main_ctl[INV2_BIT],
                    s_q.main_ctl[INV1_BIT], s_q.main_ctl[INV0_BIT]};
  assign setup   = psel & ~penable;
  assign access  = psel & penable & s_q.rdy;
  assign wr_main = access & pwrite & (paddr == OFS_MAIN_CTL);

  // counter runs only with run set; zero count is the underflow point
  assign underflow = run & (s_q.cnt == CNT_RST);

  assign pin_match = (s_q.pin == s_q.brake_ctl[BK_POL_BIT]);
  assign pin_brake = s_q.brake_ctl[BK_EN_BIT] & s_q.brake_ctl[BK_PIN_BIT] & pin_match;
  always_comb begin
    brake = 1'b0;
    if (s_q.brake_ctl[BK_EN_BIT]) begin
      if (!s_q.brake_ctl[BK_STOP_BIT] && !s_q.brake_ctl[BK_PIN_BIT]) begin
        brake = 1'b1;
      end
      if (s_q.brake_ctl[BK_STOP_BIT] && !run) begin
        brake = 1'b1;
      end
      if (pin_brake) begin
        brake = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (paddr)
      OFS_MAIN_CTL:  rd_val = {24'h00_0000, s_q.main_ctl};
      OFS_BRAKE_CTL: rd_val = {24'h00_0000, s_q.brake_ctl};
      OFS_CMP_SH4:   rd_val = {24'h00_0000, s_q.cmp_hi};
      OFS_RLD_SH0:   rd_val = {24'h00_0000, s_q.rld_lo};
      OFS_RLD_SH1:   rd_val = {30'h0000_0000, s_q.rld_hi};
      default: begin
        if (paddr >= OFS_CMP_SH0 && paddr < OFS_CMP_SH4 && paddr[1:0] == 2'h0) begin
          rd_val = {24'h00_0000, s_q.cmp_lo[paddr[3:2] - 2'h2]};
        end else begin
          rd_err = 1'b1;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    cmp_sh = CMP_ZERO;

    // apb: answer is prepared in setup, taken in the access phase
    if (setup) begin
      s_d.rdy   = 1'b1;
      s_d.err   = rd_err;
      s_d.rdata = pwrite ? 32'h0000_0000 : rd_val;
    end else if (access) begin
      s_d.rdy = 1'b0;
    end

    // brake pin: three flops, accepted when the last two agree
    s_d.sync = {s_q.sync[1:0], brake_input};
    if (s_q.sync[2] == s_q.sync[1]) begin
      s_d.pin = s_q.sync[2];
    end

    // period counter
    if (underflow) begin
      s_d.cnt = s_q.reload;
    end else if (run) begin
      s_d.cnt = s_q.cnt - 10'h001;
    end

    // waveforms are frozen while braking so brake exit restores them
    if (run && !brake) begin
      for (int n = 0; n < 4; n++) begin
        if (s_q.cmp[n] == CMP_ONES) begin
          s_d.wave[n] = 1'b0;
        end else if (underflow) begin
          s_d.wave[n] = 1'b1;
        end else if (s_q.cnt == s_q.cmp[n]) begin
          // high from reload down to compare: reload-compare+1 clocks
          s_d.wave[n] = 1'b0;
        end
      end
    end

    // shadow transfer only at underflow
    if (underflow && shadow_transfer_request) begin
      s_d.reload = {s_q.rld_hi, s_q.rld_lo};
      for (int n = 0; n < 4; n++) begin
        cmp_sh = {s_q.cmp_hi[2*n+1 -: 2], s_q.cmp_lo[n]};
        s_d.cmp[n] = cmp_sh;
      end
      s_d.main_ctl[SHADOW_TRANSFER_REQUEST_BIT] = 1'b0;
    end

    // register writes take effect at the access edge
    if (access && pwrite) begin
      unique case (paddr)
        OFS_MAIN_CTL:  s_d.main_ctl  = pwdata[7:0];
        OFS_BRAKE_CTL: s_d.brake_ctl = pwdata[7:0];
        OFS_CMP_SH4:   s_d.cmp_hi    = pwdata[7:0];
        OFS_RLD_SH0:   s_d.rld_lo    = pwdata[7:0];
        OFS_RLD_SH1:   s_d.rld_hi    = pwdata[1:0];
        default: begin
          if (paddr >= OFS_CMP_SH0 && paddr < OFS_CMP_SH4 && paddr[1:0] == 2'h0) begin
            s_d.cmp_lo[paddr[3:2] - 2'h2] = pwdata[7:0];
          end
        end
      endcase
    end
    // a transfer at the same edge as a write keeps the written request
    if (wr_main && underflow && shadow_transfer_request) begin
      s_d.main_ctl[SHADOW_TRANSFER_REQUEST_BIT] = pwdata[SHADOW_TRANSFER_REQUEST_BIT];
    end

    // pin brake overrides any run set by software
    if (pin_brake) begin
      s_d.main_ctl[RUN_BIT] = 1'b0;
    end

    // output stage
    for (int n = 0; n < 4; n++) begin
      if (brake) begin
        s_d.out[n] = s_q.brake_ctl[n];
      end else begin
        s_d.out[n] = s_q.wave[n] ^ inv[n];
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.cnt       <= CNT_RST;
      s_q.reload    <= CNT_RST;
      s_q.cmp       <= {4{CMP_ZERO}};
      s_q.main_ctl  <= MAIN_CTL_RST;
      s_q.brake_ctl <= BRAKE_CTL_RST;
      s_q.cmp_lo    <= {4{SHADOW_RST}};
      s_q.cmp_hi    <= SHADOW_RST;
      s_q.rld_lo    <= SHADOW_RST;
      s_q.rld_hi    <= 2'h0;
      s_q.wave      <= WAVE_RST;
      s_q.out       <= WAVE_RST;
      s_q.sync      <= 3'h0;
      s_q.pin       <= 1'b0;
      s_q.rdy       <= 1'b0;
      s_q.err       <= 1'b0;
      s_q.rdata     <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata     = s_q.rdata;
  assign pready     = access;
  assign pslverr    = access & s_q.err;
  assign wave_out_0 = s_q.out[0];
  assign wave_out_1 = s_q.out[1];
  assign wave_out_2 = s_q.out[2];
  assign wave_out_3 = s_q.out[3];

endmodule // fcpwm_top

// file: testbench/fcpwm_asserts.sv
/*
  Port-level checks of the four-channel pwm: apb handshake and brake levels.
  Assumes binding to fcpwm_top; mirrors brake and run writes seen on apb.
*/
`timescale 1ns/100ps
module fcpwm_asserts
  import fcpwm_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        brake_input,
  input wire logic        wave_out_0,
  input wire logic        wave_out_1,
  input wire logic        wave_out_2,
  input wire logic        wave_out_3
);
  logic [7:0] bk_q;
  logic       run_q;
  wire        wr_ev = psel & penable & pready & pwrite;
  wire  [3:0] w     = {wave_out_3, wave_out_2, wave_out_1, wave_out_0};

  // mirror of software writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bk_q  <= 8'h00;
      run_q <= 1'b0;
    end else if (wr_ev && paddr == OFS_BRAKE_CTL) begin
      bk_q <= pwdata[7:0];
    end else if (wr_ev && paddr == OFS_MAIN_CTL) begin
      run_q <= pwdata[RUN_BIT];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ready_first: assert property ((psel && !penable) ##1 (psel && penable) |-> pready)
    else $error("pready missing in access cycle");
  a_ready_idle: assert property (!psel |-> !pready)
    else $error("pready without select");
  a_err_unmapped: assert property (pready && paddr > OFS_RLD_SH1 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pready && paddr <= OFS_RLD_SH1 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_sw_brake: assert property ((bk_q[BK_EN_BIT] && !bk_q[BK_PIN_BIT] && !bk_q[BK_STOP_BIT])[*3]
    |-> w == bk_q[3:0]) else $error("software brake levels wrong");
  a_pin_brake: assert property ((bk_q[BK_EN_BIT] && bk_q[BK_PIN_BIT]
    && brake_input == bk_q[BK_POL_BIT])[*8] |-> w == bk_q[3:0]) else $error("pin brake levels wrong");
  a_halt_hold: assert property ((!run_q && !bk_q[BK_EN_BIT])[*3] |-> $stable(w))
    else $error("outputs moved while halted");
  a_reset_high: assert property ($rose(rst_n) |-> w == WAVE_RST)
    else $error("outputs not high after reset");

  cover property (wr_ev && paddr == OFS_BRAKE_CTL);
  cover property (pready && pslverr);
  cover property ($fell(wave_out_0));
endmodule // fcpwm_asserts

// file: testbench/tb_top.sv
/*
  Self-checking bench for fcpwm_top: apb tasks, high-time counts, brake.
  Assumes the package map and a zero-wait apb slave.
*/
`timescale 1ns/100ps
module tb_top
  import fcpwm_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, brake_input = 1'b0, pready, pslverr, er_v;
  logic        wave_out_0, wave_out_1, wave_out_2, wave_out_3;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic [3:0]  held;
  wire  [3:0]  w = {wave_out_3, wave_out_2, wave_out_1, wave_out_0};
  int          err_total = 0, checked = 0, hi[4] = '{40, 60, 0, 60};

  always #25 clk = ~clk;

  fcpwm_top u_fcpwm_top (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .brake_input, .wave_out_0, .wave_out_1, .wave_out_2,
    .wave_out_3);

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("Error at %0t: %s got %h exp %h", $time, m, s, e);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_v, e, "read");
  endtask

  task automatic hcnt(input int ch, input int e);
    int k;
    k = 0;
    repeat (60) begin
      @(posedge clk);
      k += int'(w[ch]);
    end
    chk(32'(k), 32'(e), "high count");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({28'h0, w}, 32'hf, "reset out");
    rd(OFS_MAIN_CTL, 32'h0);
    rd(OFS_BRAKE_CTL, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, er_v}, 32'h1, "unmapped");
    $display("test registers done");
    apb(1'b1, OFS_RLD_SH0, 32'h5);
    apb(1'b1, OFS_CMP_SH0, 32'h2);
    apb(1'b1, OFS_CMP_SH0 + 8'h08, 32'hff);
    apb(1'b1, OFS_CMP_SH0 + 8'h0c, 32'h7);
    apb(1'b1, OFS_CMP_SH4, 32'h30);
    apb(1'b1, OFS_MAIN_CTL, 32'h40);
    repeat (10) @(posedge clk);
    rd(OFS_MAIN_CTL, 32'h40);
    apb(1'b1, OFS_MAIN_CTL, 32'h80);
    hcnt(2, 60);
    apb(1'b1, OFS_MAIN_CTL, 32'hc0);
    repeat (8) @(posedge clk);
    rd(OFS_MAIN_CTL, 32'h80);
    for (int i = 0; i < 4; i++) hcnt(i, hi[i]);
    apb(1'b1, OFS_MAIN_CTL, 32'hb6);
    for (int i = 0; i < 4; i++) hcnt(i, 60 - hi[i]);
    $display("test waveforms done");
    apb(1'b1, OFS_MAIN_CTL, 32'h36);
    repeat (3) @(posedge clk);
    held = w;
    repeat (20) @(posedge clk);
    chk({28'h0, w}, {28'h0, held}, "halt hold");
    apb(1'b1, OFS_BRAKE_CTL, 32'h1a);
    repeat (4) @(posedge clk);
    chk({28'h0, w}, 32'ha, "sw brake");
    apb(1'b1, OFS_BRAKE_CTL, 32'h95);
    repeat (4) @(posedge clk);
    chk({28'h0, w}, 32'h5, "stop brake");
    apb(1'b1, OFS_BRAKE_CTL, 32'h0);
    repeat (4) @(posedge clk);
    chk({28'h0, w}, {28'h0, held}, "brake exit");
    $display("test brake done");
    apb(1'b1, OFS_MAIN_CTL, 32'hc0);
    apb(1'b1, OFS_BRAKE_CTL, 32'h7c);
    brake_input <= 1'b1;
    repeat (8) @(posedge clk);
    chk({28'h0, w}, 32'hc, "pin brake");
    apb(1'b0, OFS_MAIN_CTL, 32'h0);
    chk({31'h0, rd_v[RUN_BIT]}, 32'h0, "run cleared");
    brake_input <= 1'b0;
    $display("test pin brake done");
    test_done();
  end

  initial begin
    #(50 * 10000);
    err_total++;
    test_done();
  end
endmodule // tb_top

bind fcpwm_top fcpwm_asserts u_fcpwm_asserts (.clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .brake_input, .wave_out_0, .wave_out_1,
  .wave_out_2, .wave_out_3);
